// ---- rtl/terminal_run_map.svh ----
/*
 Constants for the terminal run-command decoder: function codes, ranges and timing.
 Assumes inclusion by its bare name from the package and the design modules.
*/
`ifndef TERMINAL_RUN_MAP_SVH
`define TERMINAL_RUN_MAP_SVH

`define CLK_HZ          25000000
`define TICK_TIME_US    10000
`define TERM_COUNT      6
`define FUNC_W          5
`define FN_COUNT        32
`define FN_NONE         5'h00
`define FN_FWD          5'h01
`define FN_REV          5'h02
`define FN_PERMIT       5'h03
`define FN_UP           5'h09
`define FN_DOWN         5'h0a
`define FN_UD_CLEAR     5'h0b
`define FN_SPEED0       5'h0c
`define FN_SPEED1       5'h0d
`define FN_SPEED2       5'h0e
`define FN_RAMP_SEL     5'h0f
`define FN_PID_PAUSE    5'h10
`define FN_TRAV_PAUSE   5'h11
`define FN_TRAV_RESET   5'h12
`define FN_RAMP_HOLD    5'h13
`define DEB_MIN         4'h1
`define DEB_MAX         4'ha
`define RATE_MIN        13'h0001
`define RATE_MAX        13'h1388
`define VOLT_MAX        11'h3e8
`define SET_MIN         12'hc18
`define SET_MAX         12'h3e8
`define FILT_MAX        10'h3e8
`define FREQ_MAX        16'hffff

`endif

// ---- rtl/terminal_run_pkg.sv ----
/*
 Types for the terminal run-command decoder: run schemes, run states and carriers.
 Assumes the constants header is on the include path.
*/
`include "terminal_run_map.svh"

package terminal_run_pkg;

    typedef logic [`FUNC_W-1:0] func_sel_t;

    typedef enum logic [1:0] {
        SCHEME_TWO_WIRE_A   = 2'h0,
        SCHEME_TWO_WIRE_B   = 2'h1,
        SCHEME_THREE_WIRE_A = 2'h2,
        SCHEME_THREE_WIRE_B = 2'h3
    } run_scheme_t;

    typedef enum logic [1:0] {
        RUN_STOP = 2'h0,
        RUN_FWD  = 2'h1,
        RUN_REV  = 2'h3
    } run_state_t;

    typedef struct packed {
        logic [10:0]        analog_low_point;
        logic signed [11:0] analog_low_setting;
        logic [10:0]        analog_high_point;
        logic signed [11:0] analog_high_setting;
        logic [9:0]         analog_filter_time;
    } analog_cfg_t;

    typedef struct packed {
        logic       run;
        logic       reverse;
        logic [2:0] speed_index;
        logic       ramp_time_set;
        logic       pid_pause;
        logic       traverse_pause;
        logic       traverse_reset;
        logic       ramp_hold;
    } drive_cmd_t;

endpackage : terminal_run_pkg

// ---- rtl/terminal_debounce.sv ----
/*
 Sample debouncer: output takes a new value only after it was sampled on
 count_limit consecutive clocks. Assumes count_limit is already within 1 to 10.
*/
`timescale 1ns/10ps
`default_nettype none

module terminal_debounce #(
    parameter int WIDTH = 1
) (
    input  wire logic             ref_clk,
    input  wire logic             rst,
    input  wire logic [3:0]       count_limit,
    input  wire logic [WIDTH-1:0] sample_in,
    output var  logic [WIDTH-1:0] stable_out
);

    logic [WIDTH-1:0] cand_reg, cand_next;
    logic [3:0]       cnt_reg, cnt_next;
    logic [WIDTH-1:0] out_reg, out_next;

    always_comb begin
        cand_next = sample_in;
        cnt_next  = cnt_reg;
        out_next  = out_reg;
        if (sample_in != cand_reg) begin
            cnt_next = 4'h1;
        end else if (cnt_reg < count_limit) begin
            cnt_next = cnt_reg + 4'h1;
        end
        if (cnt_next >= count_limit) begin
            out_next = sample_in;
        end
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            cand_reg <= '0;
            cnt_reg  <= 4'h0;
            out_reg  <= '0;
        end else begin
            cand_reg <= cand_next;
            cnt_reg  <= cnt_next;
            out_reg  <= out_next;
        end
    end

    assign stable_out = out_reg;

    AST_DEB_NEEDS_RUN: assert property (@(posedge ref_clk) disable iff (rst)
        (out_reg != $past(out_reg)) |-> (cnt_reg >= count_limit && cand_reg == out_reg))
        else $error("debounced output changed before the sample run completed");

endmodule : terminal_debounce

`default_nettype wire

// ---- rtl/terminal_run_decoder.sv ----
/*
 Terminal run-command decoder: debounces the multifunction terminals, decodes
 their functions, derives run and direction, up/down frequency and the analog setpoint.
 Assumes all inputs synchronous to ref_clk and configuration held steady while used.
*/
`timescale 1ns/10ps
`default_nettype none
`include "terminal_run_map.svh"

module terminal_run_decoder #(
    parameter int unsigned TICK_CYCLES = `TICK_TIME_US * (`CLK_HZ / 1000000)
) (
    input  wire logic                                        ref_clk,
    input  wire logic                                        rst,
    input  wire logic [`TERM_COUNT-1:0]                      term_in,
    input  wire terminal_run_pkg::func_sel_t [`TERM_COUNT-1:0] term_func,
    input  wire logic                                        halt_button,
    input  wire logic                                        ext_stop,
    input  wire terminal_run_pkg::run_scheme_t               terminal_run_scheme,
    input  wire logic [3:0]                                  terminal_debounce_count,
    input  wire logic                                        freq_source_digital,
    input  wire logic [15:0]                                 freq_command,
    input  wire logic [12:0]                                 freq_nudge_rate,
    input  wire logic                                        analog_is_current,
    input  wire logic [10:0]                                 voltage_analog_input,
    input  wire logic [10:0]                                 current_loop_input,
    input  wire terminal_run_pkg::analog_cfg_t               analog_cfg,
    output var  terminal_run_pkg::drive_cmd_t                drive_cmd,
    output var  logic [15:0]                                 set_freq,
    output var  logic signed [11:0]                          analog_setting
);

    localparam logic [13:0] TICKS_PER_S = 14'(1000000 / `TICK_TIME_US);

    // Debounce of terminals, halt button and analog sample
    logic [3:0]             deb_lim;
    logic [`TERM_COUNT:0]   dig_db;
    logic [11:0]            ana_in, ana_db;

    always_comb begin
        deb_lim = terminal_debounce_count;
        if (deb_lim < `DEB_MIN) deb_lim = `DEB_MIN;
        if (deb_lim > `DEB_MAX) deb_lim = `DEB_MAX;
    end

    assign ana_in = {analog_is_current,
                     analog_is_current ? current_loop_input : voltage_analog_input};

    terminal_debounce #(.WIDTH(`TERM_COUNT + 1)) u_dig_deb (
        .ref_clk     (ref_clk),
        .rst         (rst),
        .count_limit (deb_lim),
        .sample_in   ({halt_button, term_in}),
        .stable_out  (dig_db)
    );

    terminal_debounce #(.WIDTH(12)) u_ana_deb (
        .ref_clk     (ref_clk),
        .rst         (rst),
        .count_limit (deb_lim),
        .sample_in   (ana_in),
        .stable_out  (ana_db)
    );

    // Function decode: one-hot per terminal, OR across terminals
    logic [`TERM_COUNT-1:0][`FN_COUNT-1:0] term_hot;
    logic [`FN_COUNT-1:0]                  fn;

    for (genvar t = 0; t < `TERM_COUNT; t++) begin : g_term
        assign term_hot[t] = dig_db[t] ? (`FN_COUNT'(1) << term_func[t]) : '0;
    end

    always_comb begin
        fn = '0;
        for (int t = 0; t < `TERM_COUNT; t++) begin
            fn = fn | term_hot[t];
        end
        fn[`FN_NONE] = 1'b0;
    end

    logic forward_run_input, backward_run_input, run_permit, halt_db;
    assign forward_run_input  = fn[`FN_FWD];
    assign backward_run_input = fn[`FN_REV];
    assign run_permit         = fn[`FN_PERMIT];
    assign halt_db            = dig_db[`TERM_COUNT];

    // Timebase tick
    logic [17:0] tick_cnt_reg, tick_cnt_next;
    logic        tick;
    assign tick = (tick_cnt_reg == 18'(TICK_CYCLES - 1));
    always_comb tick_cnt_next = tick ? 18'h00000 : tick_cnt_reg + 18'h00001;

    // Run state
    terminal_run_pkg::run_state_t state_reg, state_next, wire_a, wire_b, sel_dir;
    logic block_reg, block_next, fwd_prev_reg, rev_prev_reg, trav_prev_reg;
    logic fwd_rise, rev_rise, stop3;

    always_comb begin
        wire_a = terminal_run_pkg::RUN_STOP;
        if (forward_run_input && !backward_run_input) wire_a = terminal_run_pkg::RUN_FWD;
        if (backward_run_input && !forward_run_input) wire_a = terminal_run_pkg::RUN_REV;
        sel_dir = backward_run_input ? terminal_run_pkg::RUN_REV : terminal_run_pkg::RUN_FWD;
        wire_b  = forward_run_input ? sel_dir : terminal_run_pkg::RUN_STOP;
        fwd_rise = forward_run_input && !fwd_prev_reg;
        rev_rise = backward_run_input && !rev_prev_reg;
        stop3    = halt_db || !run_permit || ext_stop;
        block_next = 1'b0;
        state_next = state_reg;
        unique case (terminal_run_scheme)
            terminal_run_pkg::SCHEME_TWO_WIRE_A: begin
                block_next = ext_stop || (block_reg && wire_a != terminal_run_pkg::RUN_STOP);
                state_next = block_next ? terminal_run_pkg::RUN_STOP : wire_a;
            end
            terminal_run_pkg::SCHEME_TWO_WIRE_B: begin
                block_next = ext_stop || (block_reg && wire_b != terminal_run_pkg::RUN_STOP);
                state_next = block_next ? terminal_run_pkg::RUN_STOP : wire_b;
            end
            terminal_run_pkg::SCHEME_THREE_WIRE_A: begin
                if (stop3) begin
                    state_next = terminal_run_pkg::RUN_STOP;
                end else if (fwd_rise || state_reg != terminal_run_pkg::RUN_STOP) begin
                    state_next = sel_dir;
                end
            end
            terminal_run_pkg::SCHEME_THREE_WIRE_B: begin
                if (stop3) begin
                    state_next = terminal_run_pkg::RUN_STOP;
                end else if (fwd_rise) begin
                    state_next = terminal_run_pkg::RUN_FWD;
                end else if (rev_rise) begin
                    state_next = terminal_run_pkg::RUN_REV;
                end
            end
        endcase
    end

    // Function flags to the drive
    terminal_run_pkg::drive_cmd_t cmd_next;
    always_comb begin
        cmd_next.run            = (state_next != terminal_run_pkg::RUN_STOP);
        cmd_next.reverse        = (state_next == terminal_run_pkg::RUN_REV);
        cmd_next.speed_index    = {fn[`FN_SPEED2], fn[`FN_SPEED1], fn[`FN_SPEED0]};
        cmd_next.ramp_time_set  = fn[`FN_RAMP_SEL];
        cmd_next.pid_pause      = fn[`FN_PID_PAUSE];
        cmd_next.traverse_pause = fn[`FN_TRAV_PAUSE];
        cmd_next.traverse_reset = fn[`FN_TRAV_RESET] && !trav_prev_reg;
        cmd_next.ramp_hold      = fn[`FN_RAMP_HOLD];
    end

    // Up/down frequency adjustment
    logic signed [17:0] offset_reg, offset_next;
    logic [13:0]        frac_reg, frac_next, step_sum, steps;
    logic [12:0]        rate_c;
    logic signed [18:0] total;
    logic [15:0]        set_freq_reg, set_freq_next;

    always_comb begin
        rate_c = freq_nudge_rate;
        if (rate_c < `RATE_MIN) rate_c = `RATE_MIN;
        if (rate_c > `RATE_MAX) rate_c = `RATE_MAX;
        step_sum    = frac_reg + {1'b0, rate_c};
        steps       = step_sum / TICKS_PER_S;
        offset_next = offset_reg;
        frac_next   = frac_reg;
        if (fn[`FN_UD_CLEAR]) begin
            offset_next = 18'sh00000;
            frac_next   = 14'h0000;
        end else if (tick && freq_source_digital && !fn[`FN_RAMP_HOLD]
                     && (fn[`FN_UP] ^ fn[`FN_DOWN])) begin
            frac_next = step_sum % TICKS_PER_S;
            if (fn[`FN_UP]) begin
                offset_next = offset_reg + $signed({4'h0, steps});
            end else begin
                offset_next = offset_reg - $signed({4'h0, steps});
            end
        end
        total = $signed({3'b000, freq_command}) + {offset_next[17], offset_next};
        if (total < 19'sh00000) begin
            total       = 19'sh00000;
            offset_next = -$signed({2'b00, freq_command});
        end else if (total > $signed({3'b000, `FREQ_MAX})) begin
            total       = $signed({3'b000, `FREQ_MAX});
            offset_next = $signed({2'b00, `FREQ_MAX}) - $signed({2'b00, freq_command});
        end
        set_freq_next = fn[`FN_RAMP_HOLD] ? set_freq_reg : total[15:0];
    end

    // Analog scaling and filter
    logic [10:0]        volt, lo, hi, den;
    logic signed [11:0] ls, hs, map_out;
    logic signed [12:0] d_v, d_s, map_sum;
    logic signed [25:0] prod, quo;
    logic signed [19:0] filt_reg, filt_next;
    logic signed [20:0] diff, fstep;
    logic [10:0]        kp1;

    always_comb begin
        volt = ana_db[11] ? {1'b0, ana_db[10:1]} : ana_db[10:0];
        if (volt > `VOLT_MAX) volt = `VOLT_MAX;
        lo = (analog_cfg.analog_low_point > `VOLT_MAX) ? `VOLT_MAX : analog_cfg.analog_low_point;
        hi = (analog_cfg.analog_high_point > `VOLT_MAX) ? `VOLT_MAX : analog_cfg.analog_high_point;
        if (hi < lo) hi = lo;
        ls = analog_cfg.analog_low_setting;
        hs = analog_cfg.analog_high_setting;
        if (ls < $signed(`SET_MIN)) ls = $signed(`SET_MIN);
        if (ls > $signed(`SET_MAX)) ls = $signed(`SET_MAX);
        if (hs < $signed(`SET_MIN)) hs = $signed(`SET_MIN);
        if (hs > $signed(`SET_MAX)) hs = $signed(`SET_MAX);
        if (volt < lo) volt = lo;
        if (volt > hi) volt = hi;
        den  = hi - lo;
        d_v  = $signed({2'b00, volt - lo});
        d_s  = {hs[11], hs} - {ls[11], ls};
        prod = d_v * d_s;
        quo  = (den == 11'h000) ? 26'sh0000000 : prod / $signed({15'h0000, den});
        map_sum = {ls[11], ls} + quo[12:0];
        map_out = map_sum[11:0];
        kp1 = ((analog_cfg.analog_filter_time > `FILT_MAX) ? {1'b0, `FILT_MAX}
              : {1'b0, analog_cfg.analog_filter_time}) + 11'h001;
        diff  = {map_out[11], map_out, 8'h00} - {filt_reg[19], filt_reg};
        fstep = diff / $signed({10'h000, kp1});
        filt_next = tick ? filt_reg + fstep[19:0] : filt_reg;
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            tick_cnt_reg  <= 18'h00000;
            state_reg     <= terminal_run_pkg::RUN_STOP;
            block_reg     <= 1'b0;
            fwd_prev_reg  <= 1'b0;
            rev_prev_reg  <= 1'b0;
            trav_prev_reg <= 1'b0;
            drive_cmd     <= '0;
            offset_reg    <= 18'sh00000;
            frac_reg      <= 14'h0000;
            set_freq_reg  <= 16'h0000;
            filt_reg      <= 20'sh00000;
        end else begin
            tick_cnt_reg  <= tick_cnt_next;
            state_reg     <= state_next;
            block_reg     <= block_next;
            fwd_prev_reg  <= forward_run_input;
            rev_prev_reg  <= backward_run_input;
            trav_prev_reg <= fn[`FN_TRAV_RESET];
            drive_cmd     <= cmd_next;
            offset_reg    <= offset_next;
            frac_reg      <= frac_next;
            set_freq_reg  <= set_freq_next;
            filt_reg      <= filt_next;
        end
    end

    assign set_freq       = set_freq_reg;
    assign analog_setting = filt_reg[19:8];

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (rst);

    AST_UD_CLEAR: assert property (fn[`FN_UD_CLEAR] |=> offset_reg == 18'sh00000)
        else $error("up/down clear did not drop the offset");
    AST_SPEED_INDEX: assert property (##1 drive_cmd.speed_index
        == $past({fn[`FN_SPEED2], fn[`FN_SPEED1], fn[`FN_SPEED0]}))
        else $error("speed index does not follow speed terminals");
    AST_PID_PAUSE: assert property (fn[`FN_PID_PAUSE] |=> drive_cmd.pid_pause)
        else $error("pid pause not raised");
    AST_TRAV_RESET: assert property ($rose(fn[`FN_TRAV_RESET]) |=> drive_cmd.traverse_reset
        ##1 !drive_cmd.traverse_reset)
        else $error("traverse reset is not a one-cycle pulse on activation");
    AST_HOLD_FREQ: assert property (fn[`FN_RAMP_HOLD] |=> $stable(set_freq_reg))
        else $error("set frequency moved under ramp inhibit");
    AST_SCHEME0_BOTH: assert property (terminal_run_scheme == terminal_run_pkg::SCHEME_TWO_WIRE_A
        && forward_run_input && backward_run_input |=> !drive_cmd.run)
        else $error("both two-wire inputs did not stop");
    AST_SCHEME1_REV: assert property (terminal_run_scheme == terminal_run_pkg::SCHEME_TWO_WIRE_B
        && !block_reg && !ext_stop && forward_run_input && backward_run_input
        |=> drive_cmd.run && drive_cmd.reverse)
        else $error("scheme 1 permit with direction did not run reverse");
    AST_TWO_WIRE_BLOCK: assert property (terminal_run_scheme[1] == 1'b0 && block_reg
        && (forward_run_input || backward_run_input) |=> !drive_cmd.run)
        else $error("two-wire restarted while input still held");
    AST_THREE_WIRE_STOP: assert property (terminal_run_scheme[1] && (halt_db || !run_permit)
        |=> !drive_cmd.run && state_reg == terminal_run_pkg::RUN_STOP)
        else $error("three-wire run not cleared by halt or permit loss");
    AST_ANALOG_CLAMP: assert property (hi > lo && !ana_db[11] && (ana_db[10:0] <= lo
        || ana_db[10:0] >= hi) |-> map_out == ((ana_db[10:0] <= lo) ? ls : hs))
        else $error("analog beyond a point not clamped to its setting");

    COV_REV_RUN: cover property (drive_cmd.run && drive_cmd.reverse);
    COV_THREE_WIRE_LATCH: cover property (terminal_run_scheme == terminal_run_pkg::SCHEME_THREE_WIRE_B
        && fwd_rise ##1 drive_cmd.run ##1 !forward_run_input && drive_cmd.run);
    COV_UP_STEP: cover property (tick && fn[`FN_UP] ##1 offset_reg > 18'sh00000);
    COV_BLOCK: cover property (block_reg && forward_run_input);

endmodule : terminal_run_decoder

`default_nettype wire

// ---- testbench/terminal_switch_panel.sv ----
/*
 Far-side model: terminal switches, halt pushbutton and one analog source.
 Assumes the bench sets switch levels off the clock's sampling edge.
*/
`timescale 1ns/10ps
`default_nettype none

module terminal_switch_panel (
    input  wire logic [5:0]  closed,
    input  wire logic        halt_pressed,
    input  wire logic        use_current,
    input  wire logic [10:0] level_cv,
    output logic      [5:0]  term_in,
    output logic             halt_button,
    output logic      [10:0] voltage_analog_input,
    output logic      [10:0] current_loop_input
);
    assign term_in     = closed;
    assign halt_button = halt_pressed;
    // The idle source shows the inverse of the live level
    assign voltage_analog_input = use_current ? ~level_cv : level_cv;
    assign current_loop_input   = use_current ? {level_cv[9:0], 1'b0} : ~level_cv;
endmodule : terminal_switch_panel

`default_nettype wire

// ---- testbench/test_terminal_run_decoder.sv ----
/*
 Self-checking bench for the terminal run-command decoder.
 Assumes the constants header and package are compiled first.
*/
`timescale 1ns/10ps
`default_nettype none
`include "terminal_run_map.svh"

module test_terminal_run_decoder;
    typedef struct {int due; int sel; logic [15:0] exp;} note_t;
    logic ref_clk = 1'b0, rst = 1'b1, ext_stop = 1'b0, halt_pressed = 1'b0;
    logic use_current = 1'b0, freq_source_digital = 1'b0;
    logic [5:0] closed = 6'h00, term_in;
    logic halt_button;
    logic [10:0] level_cv = 11'h000, voltage_analog_input, current_loop_input;
    terminal_run_pkg::func_sel_t [5:0] term_func;
    terminal_run_pkg::run_scheme_t terminal_run_scheme = terminal_run_pkg::SCHEME_TWO_WIRE_A;
    logic [3:0] terminal_debounce_count = 4'h1;
    logic [15:0] freq_command = 16'h0000, set_freq;
    logic [12:0] freq_nudge_rate = 13'h0064;
    terminal_run_pkg::analog_cfg_t analog_cfg = '{11'h0c8, 12'he0c, 11'h320, 12'h1f4, 10'h000};
    terminal_run_pkg::drive_cmd_t drive_cmd;
    logic signed [11:0] analog_setting;
    note_t notes[$];
    note_t nt;
    int failures = 0, cmp_count = 0, cyc = 0, seed = 32, r;
    logic [15:0] seen;

    always #20 ref_clk = ~ref_clk;
    always @(posedge ref_clk) cyc <= cyc + 1;

    terminal_switch_panel panel (.closed(closed), .halt_pressed(halt_pressed),
        .use_current(use_current), .level_cv(level_cv), .term_in(term_in),
        .halt_button(halt_button), .voltage_analog_input(voltage_analog_input),
        .current_loop_input(current_loop_input));

    terminal_run_decoder #(.TICK_CYCLES(10)) uut (.ref_clk(ref_clk), .rst(rst),
        .term_in(term_in), .term_func(term_func), .halt_button(halt_button),
        .ext_stop(ext_stop), .terminal_run_scheme(terminal_run_scheme),
        .terminal_debounce_count(terminal_debounce_count),
        .freq_source_digital(freq_source_digital), .freq_command(freq_command),
        .freq_nudge_rate(freq_nudge_rate), .analog_is_current(use_current),
        .voltage_analog_input(voltage_analog_input), .current_loop_input(current_loop_input),
        .analog_cfg(analog_cfg), .drive_cmd(drive_cmd), .set_freq(set_freq),
        .analog_setting(analog_setting));

    task check_val(input string what, input logic [15:0] got, input logic [15:0] exp);
        cmp_count++;
        if (got !== exp) begin
            failures++;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
        end
    endtask : check_val

    task note(input int sel, input logic [15:0] exp, input int dly = 3);
        notes.push_back('{cyc + dly, sel, exp});
    endtask : note

    task step(input int n);
        repeat (n) @(negedge ref_clk);
    endtask : step

    // Watcher: compares every due note, oldest first, against the outputs
    always @(negedge ref_clk) begin
        while (notes.size() > 0 && notes[0].due <= cyc) begin
            nt = notes.pop_front();
            case (nt.sel)
                0: seen = {14'h0, drive_cmd.run, drive_cmd.run & drive_cmd.reverse};
                1: seen = {13'h0, drive_cmd.speed_index};
                2: seen = {12'h0, drive_cmd.ramp_time_set, drive_cmd.pid_pause,
                           drive_cmd.traverse_pause, drive_cmd.ramp_hold};
                3: seen = set_freq;
                4: seen = {{4{analog_setting[11]}}, analog_setting};
                6: seen = {15'h0, drive_cmd.traverse_reset};
                default: seen = {15'h0, (set_freq + 16'h2 - nt.exp) <= 16'h4};
            endcase
            check_val($sformatf("sel%0d", nt.sel), seen, (nt.sel == 5) ? 16'h1 : nt.exp);
        end
    end

    task tally_and_finish;
        $display("compares %0d mismatches %0d", cmp_count, failures);
        if (failures == 0 && cmp_count > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask : tally_and_finish

    initial begin
        term_func = {`FN_SPEED2, `FN_SPEED1, `FN_SPEED0, `FN_PERMIT, `FN_REV, `FN_FWD};
        step(6);
        rst = 1'b0;
        note(0, 16'h0);
        step(4);
        for (int s = 0; s < 2; s++) begin
            terminal_run_scheme = terminal_run_pkg::run_scheme_t'(s);
            for (int i = 0; i < 4; i++) begin
                closed = 6'(i);
                note(0, (s == 0) ? ((i == 1) ? 16'h2 : (i == 2) ? 16'h3 : 16'h0)
                                 : ((i == 1) ? 16'h2 : (i == 3) ? 16'h3 : 16'h0));
                step(4);
            end
            closed = 6'h00;
            step(4);
        end
        terminal_run_scheme = terminal_run_pkg::SCHEME_TWO_WIRE_A;
        closed = 6'h01;
        step(4);
        ext_stop = 1'b1;
        step(1);
        ext_stop = 1'b0;
        note(0, 16'h0, 8);
        step(10);
        closed = 6'h00;
        step(4);
        closed = 6'h01;
        note(0, 16'h2);
        step(4);
        terminal_run_scheme = terminal_run_pkg::SCHEME_THREE_WIRE_B;
        closed = 6'h04;
        step(4);
        closed = 6'h05;
        step(2);
        closed = 6'h04;
        note(0, 16'h2);
        step(4);
        halt_pressed = 1'b1;
        note(0, 16'h0);
        step(4);
        halt_pressed = 1'b0;
        closed = 6'h06;
        step(2);
        closed = 6'h04;
        note(0, 16'h3);
        step(4);
        closed = 6'h00;
        note(0, 16'h0);
        step(4);
        terminal_run_scheme = terminal_run_pkg::SCHEME_THREE_WIRE_A;
        closed = 6'h06;
        step(4);
        closed = 6'h07;
        step(2);
        closed = 6'h06;
        note(0, 16'h3);
        step(4);
        closed = 6'h04;
        note(0, 16'h2);
        step(4);
        closed = 6'h00;
        terminal_run_scheme = terminal_run_pkg::SCHEME_TWO_WIRE_A;
        for (int i = 0; i < 8; i++) begin
            r = $random(seed);
            closed = {r[5:3], 3'h0};
            note(1, {13'h0, r[5:3]});
            step(4);
        end
        term_func = {`FN_RAMP_SEL, `FN_NONE, `FN_RAMP_HOLD, `FN_TRAV_PAUSE, `FN_PID_PAUSE,
                     `FN_RAMP_SEL};
        for (int i = 0; i < 8; i++) begin
            r = $random(seed);
            closed = r[5:0];
            note(2, {12'h0, r[0] | r[5], r[1], r[2], r[3]});
            note(0, 16'h0);
            step(4);
        end
        closed = 6'h00;
        term_func[4] = `FN_TRAV_RESET;
        step(2);
        closed = 6'h10;
        note(6, 16'h1, 2);
        note(6, 16'h0);
        step(4);
        term_func = {`FN_NONE, `FN_NONE, `FN_RAMP_HOLD, `FN_UD_CLEAR, `FN_DOWN, `FN_UP};
        closed = 6'h00;
        freq_command = 16'h03e8;
        freq_source_digital = 1'b1;
        note(3, 16'h03e8);
        step(4);
        closed = 6'h01;
        step(200);
        closed = 6'h00;
        note(5, 16'h03fc);
        step(4);
        closed = 6'h04;
        note(3, 16'h03e8);
        step(4);
        closed = 6'h09;
        step(100);
        closed = 6'h00;
        note(3, 16'h03e8);
        step(4);
        freq_source_digital = 1'b0;
        closed = 6'h01;
        step(100);
        closed = 6'h00;
        note(3, 16'h03e8);
        step(4);
        freq_source_digital = 1'b1;
        closed = 6'h02;
        step(200);
        closed = 6'h00;
        note(5, 16'h03d4);
        step(4);
        level_cv = 11'h28a;
        note(4, 16'h00fa, 30);
        step(34);
        level_cv = 11'h064;
        note(4, 16'hfe0c, 30);
        step(34);
        use_current = 1'b1;
        level_cv = 11'h1f4;
        note(4, 16'h0000, 30);
        step(34);
        term_func[0] = `FN_FWD;
        terminal_debounce_count = 4'ha;
        closed = 6'h01;
        step(8);
        closed = 6'h00;
        note(0, 16'h0);
        step(12);
        closed = 6'h01;
        note(0, 16'h2, 14);
        for (int w = 0; w < 50 && notes.size() > 0; w++) step(1);
        if (notes.size() > 0) failures++;
        tally_and_finish();
    end
endmodule : test_terminal_run_decoder

`default_nettype wire
